// ===== hdl/plct_top.v
// Purpose: Payload control indirect access and pattern test for one framer.
// Assumes: Register port is synchronous to sys_clk_i; timeslot strobes too.
// Notes:   Units 0, 1, 2 are transmit payload, signalling buffer, receive payload.
`include "plct_consts.vh"

module plct_top (
    input  wire       sys_clk_i,      // System clock, 125 MHz
    input  wire       rst_i,          // Synchronous reset, active high
    input  wire [7:0] reg_addr_i,     // Register offset
    input  wire [7:0] reg_wdata_i,    // Write data
    input  wire       reg_wr_i,       // Write strobe, one cycle
    input  wire       reg_rd_i,       // Read strobe, one cycle
    output reg  [7:0] reg_rdata_o,    // Read data, next cycle
    input  wire       tx_ts_valid_i,  // Transmit timeslot byte present
    input  wire [4:0] tx_ts_chan_i,   // Transmit channel number
    input  wire [7:0] tx_ts_data_i,   // Transmit byte from backplane
    output reg        tx_ts_valid_o,  // Transmit byte out present
    output reg  [7:0] tx_ts_data_o,   // Transmit byte toward line
    input  wire       rx_ts_valid_i,  // Receive timeslot byte present
    input  wire [4:0] rx_ts_chan_i,   // Receive channel number
    input  wire [7:0] rx_ts_data_i,   // Receive byte from line
    output reg        rx_ts_valid_o,  // Receive byte out present
    output reg  [7:0] rx_ts_data_o    // Receive byte toward backplane
);

    localparam [23:0] CFG_OFFS  = {`PLCT_RX_CFG,  `PLCT_SB_CFG,  `PLCT_TX_CFG};
    localparam [23:0] ADDR_OFFS = {`PLCT_RX_ADDR, `PLCT_SB_ADDR, `PLCT_TX_ADDR};
    localparam [23:0] DATA_OFFS = {`PLCT_RX_DATA, `PLCT_SB_DATA, `PLCT_TX_DATA};

    wire [23:0] cfg_all;
    wire [23:0] iaddr_all;
    wire [23:0] idata_all;
    wire [2:0]  busy_all;
    wire [2:0]  wdone_all;

    reg  [7:0]  pos_ctrl_r;
    reg  [7:0]  err_ins_r;
    reg         ins_arm_r;
    reg  [31:0] tx_test_r;
    reg  [31:0] rx_test_r;
    reg  [14:0] gen_r;
    reg  [14:0] det_r;
    reg  [3:0]  good_cnt_r;
    reg  [2:0]  bad_cnt_r;
    reg         sync_r;
    reg         bit_err_r;
    reg  [31:0] err_run_r;
    reg  [31:0] err_lat_r;

    // ======================================================================
    // Pattern functions
    // Generator: x^15 + x^14 + 1, MSB first; returns {next state, byte}
    function [22:0] prbs_gen;
        input [14:0] st;
        integer i;
        reg [14:0] s;
        reg [7:0]  b;
        reg        fb;
        begin
            s = st;
            b = 8'h00;
            for (i = 7; i >= 0; i = i - 1) begin
                fb   = s[14] ^ s[13];
                b[i] = fb;
                s    = {s[13:0], fb};
            end
            prbs_gen = {s, b};
        end
    endfunction

    // Self-synchronising check; returns {next state, mismatch}
    function [15:0] prbs_chk;
        input [14:0] st;
        input [7:0]  d;
        integer i;
        reg [14:0] s;
        reg        e;
        begin
            s = st;
            e = 1'b0;
            for (i = 7; i >= 0; i = i - 1) begin
                e = e | ((s[14] ^ s[13]) != d[i]);
                s = {s[13:0], d[i]};
            end
            prbs_chk = {s, e};
        end
    endfunction

    // ======================================================================
    // Indirect access units
    genvar u;
    generate
        for (u = 0; u < 3; u = u + 1) begin : g_unit
            reg  [7:0] cfg_r;
            reg  [7:0] iaddr_r;
            reg  [7:0] idata_r;
            reg  [1:0] phase_r;
            wire [7:0] mem_rdata;
            wire       busy = (phase_r != `PLCT_PH_IDLE);
            wire       start;

            assign start = reg_wr_i && (reg_addr_i == ADDR_OFFS[u*8 +: 8]) &&
                           cfg_r[`PLCT_ENABLE_BIT] && !busy;

            // Configuration and address registers
            always @(posedge sys_clk_i) begin
                if (rst_i) begin
                    cfg_r   <= `PLCT_REG_RST;
                    iaddr_r <= `PLCT_REG_RST;
                end else begin
                    if (reg_wr_i && reg_addr_i == CFG_OFFS[u*8 +: 8]) begin
                        cfg_r <= reg_wdata_i;
                    end
                    if (start) begin
                        iaddr_r <= reg_wdata_i;
                    end
                end
            end

            always @(posedge sys_clk_i) begin
                if (rst_i) begin
                    phase_r <= `PLCT_PH_IDLE;
                    idata_r <= `PLCT_REG_RST;
                end else begin
                    case (phase_r)
                        `PLCT_PH_IDLE: begin
                            if (start) begin
                                phase_r <= `PLCT_PH_ACCESS;
                            end
                            if (reg_wr_i && reg_addr_i == DATA_OFFS[u*8 +: 8]) begin
                                idata_r <= reg_wdata_i;
                            end
                        end
                        `PLCT_PH_ACCESS: begin
                            phase_r <= `PLCT_PH_DONE;
                        end
                        `PLCT_PH_DONE: begin
                            phase_r <= `PLCT_PH_IDLE;
                            if (iaddr_r[`PLCT_READ_BIT]) begin
                                idata_r <= mem_rdata;
                            end
                        end
                        default: begin
                            phase_r <= `PLCT_PH_IDLE;
                        end
                    endcase
                end
            end

            plct_ind_mem #(
                .AW    (`PLCT_IND_AW),
                .DEPTH (`PLCT_IND_DEPTH)
            ) u_mem (
                .sys_clk_i (sys_clk_i),
                .en_i      (phase_r == `PLCT_PH_ACCESS),
                .we_i      (!iaddr_r[`PLCT_READ_BIT]),
                .addr_i    (iaddr_r[`PLCT_IND_AW-1:0]),
                .wdata_i   (idata_r),
                .rdata_o   (mem_rdata)
            );

            assign cfg_all[u*8 +: 8]   = cfg_r;
            assign iaddr_all[u*8 +: 8] = iaddr_r;
            assign idata_all[u*8 +: 8] = idata_r;
            assign busy_all[u]         = busy;
            assign wdone_all[u]        = (phase_r == `PLCT_PH_DONE) &&
                                         !iaddr_r[`PLCT_READ_BIT];
        end
    endgenerate

    // ======================================================================
    // Test-bit shadows
    // A copy of each channel's test bit lets the data path look it up
    // every byte without stealing cycles from the single-port store.
    always @(posedge sys_clk_i) begin
        if (rst_i) begin
            tx_test_r <= 32'h0000_0000;
            rx_test_r <= 32'h0000_0000;
        end else begin
            if (wdone_all[0] && iaddr_all[6:5] == 2'h0) begin
                tx_test_r[iaddr_all[4:0]] <= idata_all[`PLCT_TEST_BIT];
            end
            if (wdone_all[2] && iaddr_all[22:21] == 2'h0) begin
                rx_test_r[iaddr_all[20:16]] <= idata_all[16 + `PLCT_TEST_BIT];
            end
        end
    end

    // ======================================================================
    // Direct control registers
    wire backplane = pos_ctrl_r[`PLCT_BACKPLANE_BIT];
    wire ins_rise  = reg_wr_i && reg_addr_i == `PLCT_ERR_INS &&
                     reg_wdata_i[`PLCT_INSERT_BIT] && !err_ins_r[`PLCT_INSERT_BIT];
    wire tx_on     = cfg_all[`PLCT_ENABLE_BIT] && tx_test_r[tx_ts_chan_i];
    wire rx_on     = cfg_all[16 + `PLCT_ENABLE_BIT] && rx_test_r[rx_ts_chan_i];

    wire gen_go    = backplane ? (rx_ts_valid_i && rx_on) : (tx_ts_valid_i && tx_on);
    wire chk_go    = backplane ? (tx_ts_valid_i && tx_on) : (rx_ts_valid_i && rx_on);
    wire [7:0] chk_byte = backplane ? tx_ts_data_i : rx_ts_data_i;

    wire [22:0] gen_res  = prbs_gen(gen_r);
    // one inverted bit per armed insertion
    wire [7:0]  gen_byte = gen_res[7:0] ^ {7'h00, ins_arm_r};
    wire [15:0] chk_res  = prbs_chk(det_r, chk_byte);
    wire        byte_err = chk_go && chk_res[0];

    // Position, insertion control and the one-shot arm
    always @(posedge sys_clk_i) begin
        if (rst_i) begin
            pos_ctrl_r <= `PLCT_REG_RST;
            err_ins_r  <= `PLCT_REG_RST;
            ins_arm_r  <= 1'b0;
        end else begin
            if (reg_wr_i && reg_addr_i == `PLCT_POS_CTRL) begin
                pos_ctrl_r <= reg_wdata_i;
            end
            if (reg_wr_i && reg_addr_i == `PLCT_ERR_INS) begin
                err_ins_r <= reg_wdata_i;
            end
            if (ins_rise) begin
                ins_arm_r <= 1'b1;
            end else if (gen_go) begin
                ins_arm_r <= 1'b0;
            end
        end
    end

    // ======================================================================
    // Data path: generator insertion
    always @(posedge sys_clk_i) begin
        if (rst_i) begin
            gen_r         <= `PLCT_PRBS_SEED;
            tx_ts_valid_o <= 1'b0;
            rx_ts_valid_o <= 1'b0;
            tx_ts_data_o  <= 8'h00;
            rx_ts_data_o  <= 8'h00;
        end else begin
            tx_ts_valid_o <= tx_ts_valid_i;
            rx_ts_valid_o <= rx_ts_valid_i;
            tx_ts_data_o  <= (!backplane && tx_on) ? gen_byte : tx_ts_data_i;
            rx_ts_data_o  <= (backplane && rx_on) ? gen_byte : rx_ts_data_i;
            if (gen_go) begin
                gen_r <= gen_res[22:8];
            end
        end
    end

    // ======================================================================
    // Detector: sync search and error flag
    // Self-synchronising check: one line error shows as up to three bit
    // mismatches, which may span three bytes; counting is per errored byte.
    always @(posedge sys_clk_i) begin
        if (rst_i) begin
            det_r      <= `PLCT_PRBS_SEED;
            good_cnt_r <= 4'h0;
            bad_cnt_r  <= 3'h0;
            sync_r     <= 1'b0;
            bit_err_r  <= 1'b0;
        end else begin
            if (chk_go) begin
                det_r <= chk_res[15:1];
                if (byte_err) begin
                    good_cnt_r <= 4'h0;
                    if (bad_cnt_r == `PLCT_SYNC_LOSS - 3'h1) begin
                        sync_r <= 1'b0;
                    end else begin
                        bad_cnt_r <= bad_cnt_r + 3'h1;
                    end
                end else begin
                    bad_cnt_r <= 3'h0;
                    if (good_cnt_r == `PLCT_SYNC_GOOD) begin
                        sync_r <= 1'b1;
                    end else begin
                        good_cnt_r <= good_cnt_r + 4'h1;
                    end
                end
            end
            // sticky error flag, read clears, set wins
            if (byte_err) begin
                bit_err_r <= 1'b1;
            end else if (reg_rd_i && reg_addr_i == `PLCT_DET_STAT) begin
                bit_err_r <= 1'b0;
            end
        end
    end

    // ======================================================================
    // Error counter and latch
    wire cnt_latch = reg_wr_i && reg_addr_i == `PLCT_ERR_CNT0;
    wire cnt_inc   = byte_err && sync_r && err_run_r != 32'hFFFF_FFFF;

    // write latches count and restarts it
    always @(posedge sys_clk_i) begin
        if (rst_i) begin
            err_run_r <= 32'h0000_0000;
            err_lat_r <= 32'h0000_0000;
        end else if (cnt_latch) begin
            err_lat_r <= err_run_r;
            err_run_r <= {31'h0000_0000, byte_err && sync_r};
        end else if (cnt_inc) begin
            err_run_r <= err_run_r + 32'h0000_0001;
        end
    end

    // ======================================================================
    // Register read mux, data valid the cycle after the read strobe
    always @(posedge sys_clk_i) begin
        if (rst_i) begin
            reg_rdata_o <= 8'h00;
        end else if (reg_rd_i) begin
            case (reg_addr_i)
                `PLCT_POS_CTRL: reg_rdata_o <= pos_ctrl_r;
                `PLCT_TX_CFG:   reg_rdata_o <= cfg_all[7:0];
                `PLCT_SB_CFG:   reg_rdata_o <= cfg_all[15:8];
                `PLCT_RX_CFG:   reg_rdata_o <= cfg_all[23:16];
                `PLCT_TX_STAT:  reg_rdata_o <= {busy_all[0], 7'h00};
                `PLCT_SB_STAT:  reg_rdata_o <= {busy_all[1], 7'h00};
                `PLCT_RX_STAT:  reg_rdata_o <= {busy_all[2], 7'h00};
                `PLCT_TX_ADDR:  reg_rdata_o <= iaddr_all[7:0];
                `PLCT_SB_ADDR:  reg_rdata_o <= iaddr_all[15:8];
                `PLCT_RX_ADDR:  reg_rdata_o <= iaddr_all[23:16];
                `PLCT_TX_DATA:  reg_rdata_o <= idata_all[7:0];
                `PLCT_SB_DATA:  reg_rdata_o <= idata_all[15:8];
                `PLCT_RX_DATA:  reg_rdata_o <= idata_all[23:16];
                // sync at b4, error at b2
                `PLCT_DET_STAT: reg_rdata_o <= {3'h0, sync_r, 1'b0, bit_err_r, 2'h0};
                `PLCT_ERR_INS:  reg_rdata_o <= err_ins_r;
                `PLCT_ERR_CNT0: reg_rdata_o <= err_lat_r[7:0];
                `PLCT_ERR_CNT1: reg_rdata_o <= err_lat_r[15:8];
                `PLCT_ERR_CNT2: reg_rdata_o <= err_lat_r[23:16];
                `PLCT_ERR_CNT3: reg_rdata_o <= err_lat_r[31:24];
                default:        reg_rdata_o <= 8'h00;
            endcase
        end
    end

endmodule // plct_top

// ===== shared/plct_consts.vh
// Purpose: Constants for the payload control and pattern test block.
// Assumes: One framer's 8-bit register window, 8-bit data.
// Notes:   Offsets are byte offsets inside the framer's register window.
`ifndef PLCT_CONSTS_VH
`define PLCT_CONSTS_VH

// ==========================================================================
// Register offsets
`define PLCT_POS_CTRL       8'h0F
`define PLCT_TX_CFG         8'h30
`define PLCT_TX_STAT        8'h31
`define PLCT_SB_CFG         8'h40
`define PLCT_SB_STAT        8'h41
`define PLCT_SB_ADDR        8'h42
`define PLCT_SB_DATA        8'h43
`define PLCT_RX_CFG         8'h50
`define PLCT_RX_STAT        8'h51
`define PLCT_DET_STAT       8'h61
`define PLCT_ERR_INS        8'h64
`define PLCT_ERR_CNT0       8'h6C
`define PLCT_ERR_CNT1       8'h6D
`define PLCT_ERR_CNT2       8'h6E
`define PLCT_ERR_CNT3       8'h6F
`define PLCT_TX_ADDR        8'hB2
`define PLCT_TX_DATA        8'hB3
`define PLCT_RX_ADDR        8'hD2
`define PLCT_RX_DATA        8'hD3

// ==========================================================================
// Field positions
`define PLCT_ENABLE_BIT     0
`define PLCT_BUSY_BIT       7
`define PLCT_READ_BIT       7
`define PLCT_TEST_BIT       3
`define PLCT_BACKPLANE_BIT  2
`define PLCT_SYNC_BIT       4
`define PLCT_BITERR_BIT     2
`define PLCT_INSERT_BIT     3

// ==========================================================================
// Sizes, reset values and counts
`define PLCT_IND_AW         7
`define PLCT_IND_DEPTH      128
`define PLCT_REG_RST        8'h00
`define PLCT_PRBS_SEED      15'h7FFF
`define PLCT_SYNC_GOOD      4'hF
`define PLCT_SYNC_LOSS      3'h4
`define PLCT_PH_IDLE        2'h0
`define PLCT_PH_ACCESS      2'h1
`define PLCT_PH_DONE        2'h2

`endif

// ===== hdl/plct_ind_mem.v
// Purpose: Indirect per-channel control store of one unit.
// Assumes: One access per cycle, write or read.
// Notes:   Contents are not reset; software clears them before use.
module plct_ind_mem #(
    parameter AW    = 7,
    parameter DEPTH = 128
) (
    input  wire          sys_clk_i,  // System clock
    input  wire          en_i,       // Access strobe
    input  wire          we_i,       // Write when high
    input  wire [AW-1:0] addr_i,     // Channel location
    input  wire [7:0]    wdata_i,    // Write data
    output reg  [7:0]    rdata_o     // Registered read data
);

    reg [7:0] mem_r [0:DEPTH-1];

    // ======================================================================
    // Storage
    // Read data comes from a flop so the bus mux sees a clean value
    always @(posedge sys_clk_i) begin
        if (en_i) begin
            if (we_i) begin
                mem_r[addr_i] <= wdata_i;
            end
            rdata_o <= mem_r[addr_i];
        end
    end

endmodule // plct_ind_mem

// ===== sim/plct_top_props.sv
// Purpose: Port-level checker for the payload control and pattern test block.
// Assumes: Sees only plct_top ports; one clock domain.
// Notes:   Busy is mirrored for the transmit unit only, to keep helper logic small.
`include "plct_consts.vh"

module plct_top_props (
    input wire       sys_clk_i,     // System clock
    input wire       rst_i,         // Synchronous reset
    input wire [7:0] reg_addr_i,    // Register offset
    input wire [7:0] reg_wdata_i,   // Write data
    input wire       reg_wr_i,      // Write strobe
    input wire       reg_rd_i,      // Read strobe
    input wire [7:0] reg_rdata_o,   // Read data
    input wire       tx_ts_valid_i, // Transmit byte in
    input wire       tx_ts_valid_o, // Transmit byte out
    input wire       rx_ts_valid_i, // Receive byte in
    input wire       rx_ts_valid_o  // Receive byte out
);
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (rst_i);

    // ======================================================================
    // Busy mirror: an accepted address write keeps busy up for two cycles
    logic       tx_en_r;
    logic [1:0] tx_cnt_r;
    always @(posedge sys_clk_i) begin
        if (rst_i) begin
            tx_en_r  <= 1'b0;
            tx_cnt_r <= 2'h0;
        end else begin
            if (reg_wr_i && reg_addr_i == `PLCT_TX_CFG)
                tx_en_r <= reg_wdata_i[0];
            // Refused while disabled or busy, so the count is not reloaded
            if (reg_wr_i && reg_addr_i == `PLCT_TX_ADDR && tx_en_r && tx_cnt_r == 2'h0)
                tx_cnt_r <= 2'h2;
            else if (tx_cnt_r != 2'h0)
                tx_cnt_r <= tx_cnt_r - 2'h1;
        end
    end

    // ======================================================================
    // Assertions
    a_reset_clear: assert property ($fell(rst_i) |-> reg_rdata_o == 8'h00 && !tx_ts_valid_o)
        else $error("outputs not cleared by reset");
    a_rdata_hold: assert property (!reg_rd_i |=> $stable(reg_rdata_o))
        else $error("read data moved without a read");
    a_tx_busy_flag: assert property (reg_rd_i && reg_addr_i == `PLCT_TX_STAT
        |=> reg_rdata_o == {$past(tx_cnt_r != 2'h0), 7'h00}) else $error("tx busy flag wrong");
    a_stat_low_zero: assert property (reg_rd_i && (reg_addr_i == `PLCT_SB_STAT
        || reg_addr_i == `PLCT_RX_STAT) |=> reg_rdata_o[6:0] == 7'h00)
        else $error("status low bits not zero");
    a_unmapped_zero: assert property (reg_rd_i && reg_addr_i == 8'h01 |=> reg_rdata_o == 8'h00)
        else $error("unmapped read not zero");
    a_cfg_readback: assert property ((reg_wr_i && reg_addr_i == `PLCT_RX_CFG) ##2
        (reg_rd_i && reg_addr_i == `PLCT_RX_CFG) |=> reg_rdata_o[0] == $past(reg_wdata_i[0], 3))
        else $error("enable bit readback wrong");
    a_tx_ts_pipe: assert property (tx_ts_valid_i |=> tx_ts_valid_o)
        else $error("tx byte timing wrong");
    a_rx_ts_pipe: assert property (rx_ts_valid_o == $past(rx_ts_valid_i))
        else $error("rx byte timing wrong");

    c_busy_seen: cover property (reg_rd_i && reg_addr_i == `PLCT_TX_STAT ##1 reg_rdata_o[7]);
    c_sync_seen: cover property (reg_rd_i && reg_addr_i == `PLCT_DET_STAT ##1 reg_rdata_o[4]);
    c_err_seen: cover property (reg_rd_i && reg_addr_i == `PLCT_DET_STAT ##1 reg_rdata_o[2]);
endmodule // plct_top_props

// ===== sim/plct_line_loop.sv
// Purpose: Far-end model that loops transmit timeslots back into receive.
// Assumes: Channel number of the byte is that presented with the input byte.
// Notes:   Between bytes the data lines toggle every cycle, starting with the inverse of the last byte.
module plct_line_loop (
    input  wire        sys_clk_i,     // System clock
    input  wire        tx_ts_valid_o, // Byte from the framer
    input  wire [7:0]  tx_ts_data_o,  // Its data
    input  wire [4:0]  tx_ts_chan_i,  // Channel presented a cycle earlier
    output logic       rx_ts_valid_i, // Looped byte present
    output logic [4:0] rx_ts_chan_i,  // Looped channel
    output logic [7:0] rx_ts_data_i   // Looped data
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [4:0] chan_d = 5'h00;

    initial begin
        rx_ts_valid_i = 1'b0;
        rx_ts_chan_i  = 5'h00;
        rx_ts_data_i  = 8'h00;
    end

    // One cycle of line delay; idle data toggles so stale bytes never pass
    always @(posedge sys_clk_i) begin
        chan_d        <= tx_ts_chan_i;
        rx_ts_valid_i <= tx_ts_valid_o;
        rx_ts_chan_i  <= chan_d;
        rx_ts_data_i  <= tx_ts_valid_o ? tx_ts_data_o : ~rx_ts_data_i;
    end
endmodule // plct_line_loop

// ===== sim/plct_top_bench.sv
// Purpose: Self-checking bench for the payload control and pattern test block.
// Assumes: Line side looped back by plct_line_loop; 24 channels per frame.
// Notes:   Backplane bytes are a constant 5A.
`include "plct_consts.vh"
`define CHECK_EQ(what, exp, got) begin comparisons++; \
    if ((got) !== (exp)) begin num_errors++; \
    $display("Error %s expected %h seen %h", what, exp, got); end end

module plct_top_bench;
    timeunit 1ns;
    timeprecision 1ps;
    logic       sys_clk_i = 1'b0;
    logic       rst_i = 1'b1;
    logic [7:0] reg_addr_i = 8'h00;
    logic [7:0] reg_wdata_i = 8'h00;
    logic       reg_wr_i = 1'b0;
    logic       reg_rd_i = 1'b0;
    logic       tx_ts_valid_i = 1'b0;
    logic [4:0] tx_ts_chan_i = 5'h00;
    logic [7:0] tx_ts_data_i = 8'h5A;
    wire  [7:0] reg_rdata_o, tx_ts_data_o, rx_ts_data_i, rx_ts_data_o;
    wire        tx_ts_valid_o, rx_ts_valid_i, rx_ts_valid_o;
    wire  [4:0] rx_ts_chan_i;
    logic [4:0] tx_chan_d, rx_chan_d;
    logic [7:0] tx_last [0:31];
    logic [7:0] rx_last [0:31];
    logic [7:0] first_pat;
    logic       got_first = 1'b0;
    logic       ts_on = 1'b0;
    int         num_errors = 0;
    int         comparisons = 0;
    int         cycles = 0;

    always #4 sys_clk_i = ~sys_clk_i;

    plct_top dut (.*);
    plct_line_loop u_loop (.*);

    // Timeslot source: one byte every other cycle, channels 1..23 then 0
    always @(posedge sys_clk_i) begin
        if (ts_on && !tx_ts_valid_i) begin
            tx_ts_valid_i <= 1'b1;
            tx_ts_chan_i  <= (tx_ts_chan_i == 5'h17) ? 5'h00 : tx_ts_chan_i + 5'h01;
        end else
            tx_ts_valid_i <= 1'b0;
    end

    // Monitor of both outputs, and the run limit
    always @(posedge sys_clk_i) begin
        tx_chan_d <= tx_ts_chan_i;
        rx_chan_d <= rx_ts_chan_i;
        if (tx_ts_valid_o) tx_last[tx_chan_d] <= tx_ts_data_o;
        if (rx_ts_valid_o) rx_last[rx_chan_d] <= rx_ts_data_o;
        if (tx_ts_valid_o && tx_chan_d == 5'h02 && !got_first) begin
            first_pat <= tx_ts_data_o;
            got_first <= 1'b1;
        end
        cycles++;
        if (cycles == 40000) begin
            num_errors++;
            stop_test();
        end
    end

    // ======================================================================
    // Register port tasks
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        reg_addr_i  <= a;
        reg_wdata_i <= d;
        reg_wr_i    <= 1'b1;
        @(posedge sys_clk_i);
        reg_wr_i <= 1'b0;
        @(posedge sys_clk_i);
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        reg_addr_i <= a;
        reg_rd_i   <= 1'b1;
        @(posedge sys_clk_i);
        reg_rd_i <= 1'b0;
        @(posedge sys_clk_i);
        d = reg_rdata_o;
    endtask
    task automatic wait_idle(input logic [7:0] st);
        logic [7:0] v = 8'h80;
        for (int n = 0; n < 20 && v[7] !== 1'b0; n++) rd(st, v);
        `CHECK_EQ("busy", 1'b0, v[7])
    endtask
    task automatic ind_wr(input logic [7:0] ad, st, loc, d);
        wr(ad + 8'h01, d);
        wr(ad, loc);
        wait_idle(st);
    endtask
    task automatic ind_rd(input logic [7:0] ad, st, loc, output logic [7:0] d);
        wr(ad, 8'h80 | loc);
        wait_idle(st);
        rd(ad + 8'h01, d);
    endtask

    // ======================================================================
    // Scenarios
    task automatic t_reset_values();
        logic [7:0] regs [12] = '{8'h0F, 8'h30, 8'h31, 8'h40, 8'h41, 8'h50, 8'h51, 8'h61,
                                  8'h64, 8'h6C, 8'h6F, 8'h01};
        logic [7:0] v;
        foreach (regs[i]) begin
            rd(regs[i], v);
            `CHECK_EQ("reset value", 8'h00, v)
        end
    endtask
    task automatic t_init();
        logic [7:0] v;
        wr(`PLCT_TX_CFG, 8'h01);
        wr(`PLCT_SB_CFG, 8'h01);
        wr(`PLCT_RX_CFG, 8'h01);
        rd(`PLCT_RX_CFG, v);
        `CHECK_EQ("rx enable", 8'h01, v)
        // Zero all used locations
        for (int i = 0; i <= 8'h48; i++) ind_wr(`PLCT_TX_ADDR, `PLCT_TX_STAT, i, 8'h00);
        for (int i = 0; i <= 8'h18; i++) ind_wr(`PLCT_SB_ADDR, `PLCT_SB_STAT, i, 8'h00);
        for (int i = 0; i <= 8'h18; i++) ind_wr(`PLCT_RX_ADDR, `PLCT_RX_STAT, i, 8'h00);
    endtask
    task automatic t_refused();
        logic [7:0] v;
        wr(`PLCT_TX_CFG, 8'h00);
        wr(`PLCT_TX_DATA, 8'h08);
        wr(`PLCT_TX_ADDR, 8'h02);
        rd(`PLCT_TX_STAT, v);
        `CHECK_EQ("busy while disabled", 1'b0, v[7])
        wr(`PLCT_TX_CFG, 8'h01);
        ind_rd(`PLCT_TX_ADDR, `PLCT_TX_STAT, 8'h02, v);
        `CHECK_EQ("refused write", 8'h00, v)
        // Address write while busy is dropped
        wr(`PLCT_TX_DATA, 8'h08);
        wr(`PLCT_TX_ADDR, 8'h03);
        wr(`PLCT_TX_ADDR, 8'h06);
        wait_idle(`PLCT_TX_STAT);
        ind_rd(`PLCT_TX_ADDR, `PLCT_TX_STAT, 8'h06, v);
        `CHECK_EQ("write while busy", 8'h00, v)
        ind_rd(`PLCT_TX_ADDR, `PLCT_TX_STAT, 8'h03, v);
        `CHECK_EQ("first write kept", 8'h08, v)
        ind_wr(`PLCT_TX_ADDR, `PLCT_TX_STAT, 8'h03, 8'h00);
    endtask
    task automatic t_test_bits();
        logic [7:0] chans [3] = '{8'h02, 8'h04, 8'h05};
        logic [7:0] v;
        foreach (chans[i]) begin
            ind_wr(`PLCT_TX_ADDR, `PLCT_TX_STAT, chans[i], 8'h08);
            ind_wr(`PLCT_RX_ADDR, `PLCT_RX_STAT, chans[i], 8'h08);
        end
        ind_rd(`PLCT_RX_ADDR, `PLCT_RX_STAT, 8'h04, v);
        `CHECK_EQ("rx test bit", 8'h08, v)
        ts_on <= 1'b1;
        repeat (700) @(posedge sys_clk_i);
        // All-ones seed gives a zero first byte
        `CHECK_EQ("first pattern byte", 8'h00, first_pat)
        `CHECK_EQ("plain channel", 8'h5A, tx_last[3])
        rd(`PLCT_DET_STAT, v);
        rd(`PLCT_DET_STAT, v);
        `CHECK_EQ("sync", 2'b10, {v[4], v[2]})
    endtask
    task automatic t_error_insert();
        logic [7:0] v;
        logic [31:0] cnt;
        wr(`PLCT_ERR_CNT0, 8'h00);
        repeat (3) begin
            wr(`PLCT_ERR_INS, 8'h08);
            wr(`PLCT_ERR_INS, 8'h00);
            repeat (200) @(posedge sys_clk_i);
        end
        rd(`PLCT_DET_STAT, v);
        `CHECK_EQ("error flag", 2'b11, {v[4], v[2]})
        // Second latch sees a restarted, empty count
        for (int k = 0; k < 2; k++) begin
            wr(`PLCT_ERR_CNT0, 8'h00);
            for (int i = 3; i >= 0; i--) begin
                rd(`PLCT_ERR_CNT0 + i, v);
                cnt = {cnt[23:0], v};
            end
            if (k == 0) `CHECK_EQ("count range", 1'b1, cnt >= 32'h3 && cnt <= 32'h6)
            else `CHECK_EQ("restarted count", 32'h0, cnt)
        end
    endtask
    task automatic t_backplane();
        logic [7:0] v;
        wr(`PLCT_POS_CTRL, 8'h04);
        repeat (400) @(posedge sys_clk_i);
        `CHECK_EQ("tx test passes", 8'h5A, tx_last[2])
        `CHECK_EQ("rx carries pattern", 1'b1, rx_last[2] !== 8'h5A)
        rd(`PLCT_DET_STAT, v);
        rd(`PLCT_DET_STAT, v);
        `CHECK_EQ("sync on backplane", 1'b0, v[4])
    endtask

    task automatic stop_test();
        $display("comparisons %0d num_errors %0d", comparisons, num_errors);
        if (num_errors == 0 && comparisons > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    initial begin
        repeat (20) @(posedge sys_clk_i);
        rst_i <= 1'b0;
        repeat (2) @(posedge sys_clk_i);
        t_reset_values();
        t_init();
        t_refused();
        t_test_bits();
        t_error_insert();
        t_backplane();
        stop_test();
    end
endmodule // plct_top_bench

bind plct_top plct_top_props u_props (.*);
